// ---- core/perf_cnt_pkg.sv ----
// Constants, types and cascade maps for the event counter bank.
// Operation
// - A set enable flag makes the counter accumulate events until cleared.
// - With cascading set, a source overflow starts its partner without software.
// - Counter values read back at any time, counting or stopped.
// - Passing the maximum wraps the counter to zero and it keeps counting.
// - Each wrap sets a sticky overflow flag that holds until cleared.
// - Clearing enable halts the counter and holds its value.
// - A cascade-started counter stops on its cascade flag or source overflow clearing.
// - Eighteen counters with one configuration register each, nine pairs, four blocks.
// - Blocks 0 to 2 hold two pairs; block 3 holds counters 12 to 17.
// - Only counters 0 to 15 take events through the event selection.
// - In a block, counters two apart below 16 cascade either way, forming two chains.
// - Through the ordinary cascade bit, counter 16 starts only from 14, 17 only from 15.
// - Software arms a target with cascade 1, enable 0; hardware then starts it.
// - A counter preset to minus N overflows on its Nth event.
// - Bit 11 of block 3 registers gives extended cascading, only on family 15 model 2+.
// - Extended bit: reg 0 from 4, reg 3 from 5, reg 4 from 5, reg 5 from 4.
// - Counters 16 and 17 never start others through the ordinary cascade bit.
// - A set extended bit lets overflow of 16 or 17 start the designated counter.
// - Overflow with interrupt enable set raises the performance monitor interrupt.
// - With force overflow set, every increment counts as an overflow.
package perf_cnt_pkg;

    localparam int NUM_CNT = 18;
    localparam int SEL_CNT = 16;
    localparam int QUEUE_BASE = 12;
    localparam int EV_LANES = 4;
    localparam int EV_GROUPS = 8;
    localparam int DED_CNT = NUM_CNT - SEL_CNT;

    localparam logic [3:0] REGION_CFG = 4'h0;
    localparam logic [3:0] REGION_CNT_LO = 4'h1;
    localparam logic [3:0] REGION_CNT_HI = 4'h2;

    localparam int CFG_EXT_BIT = 11;
    localparam int CFG_EN_BIT = 12;
    localparam int CFG_SEL_LSB = 13;
    localparam int CFG_SEL_W = 3;
    localparam int CFG_FORCE_BIT = 25;
    localparam int CFG_IRQ_BIT = 26;
    localparam int CFG_CASC_BIT = 30;
    localparam int CFG_OVF_BIT = 31;

    localparam int EXT_FAMILY = 15;
    localparam int EXT_MIN_MODEL = 2;

    typedef struct packed {
        logic cascade;
        logic irqEn;
        logic forceOvf;
        logic [CFG_SEL_W-1:0] evSel;
        logic enable;
        logic extCasc;
    } cfg_t;

    localparam cfg_t CFG_RESET = '0;

    // Ordinary cascade source: two apart inside a block, 16 and 17 never act as source.
    function automatic int ord_src(input int i);
        return (i < SEL_CNT) ? (i ^ 2) : (i - 2);
    endfunction

    function automatic bit ext_ok(input int i);
        return (i == QUEUE_BASE) || (i == QUEUE_BASE + 3) || (i == QUEUE_BASE + 4)
            || (i == QUEUE_BASE + 5);
    endfunction

    function automatic int ext_src(input int i);
        int s;
        s = QUEUE_BASE + 4;
        if ((i == QUEUE_BASE + 3) || (i == QUEUE_BASE + 4)) begin
            s = QUEUE_BASE + 5;
        end
        return s;
    endfunction

endpackage

// ---- core/perf_counter_unit.sv ----
// One wrapping event counter with sticky overflow flag.
`timescale 1ns/100ps
module perf_counter_unit #(
    parameter int CNT_W = 40
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic run,
    input wire logic [3:0] incVal,
    input wire logic forceOvf,
    input wire logic loadLo,
    input wire logic loadHi,
    input wire logic [31:0] wrData,
    input wire logic clearOvf,
    output logic [CNT_W-1:0] count,
    output logic ovfFlag,
    output logic ovfPulse
);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic ovfFlag_r;
    logic ovfFlag_nxt;
    logic ovfPulse_r;
    logic ovfPulse_nxt;

    always_comb begin
        logic [CNT_W:0] sum;
        logic [63:0] wide;
        logic wrap;
        sum = {1'b0, count_r} + {{(CNT_W - 3){1'b0}}, incVal};
        wrap = run & (sum[CNT_W] | (forceOvf & (incVal != 4'h0)));
        wide = 64'(count_r);
        if (run) begin
            wide = 64'(sum[CNT_W-1:0]);
        end
        if (loadLo) begin
            wide[31:0] = wrData;
        end
        if (loadHi) begin
            wide[63:32] = wrData;
        end
        count_nxt = wide[CNT_W-1:0];
        ovfPulse_nxt = wrap;
        // A wrap in the clearing cycle wins so no overflow goes unrecorded.
        ovfFlag_nxt = wrap | (ovfFlag_r & ~clearOvf);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_r <= '0;
            ovfFlag_r <= 1'b0;
            ovfPulse_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            ovfFlag_r <= ovfFlag_nxt;
            ovfPulse_r <= ovfPulse_nxt;
        end
    end

    assign count = count_r;
    assign ovfFlag = ovfFlag_r;
    assign ovfPulse = ovfPulse_r;

endmodule

// ---- core/perf_counter_bank.sv ----
// Eighteen-counter event bank with cascading and an APB register port.
`timescale 1ns/100ps
module perf_counter_bank #(
    parameter int CNT_W = 40,
    parameter int FAMILY = 15,
    parameter int MODEL = 2
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [perf_cnt_pkg::EV_GROUPS*perf_cnt_pkg::EV_LANES-1:0] eventGroups,
    input wire logic [perf_cnt_pkg::DED_CNT*perf_cnt_pkg::EV_LANES-1:0] dedicatedEvents,
    output logic perfmonInterrupt
);

    initial begin
        if (CNT_W < 5 || CNT_W > 64) begin
            $error("CNT_W must lie between 5 and 64");
        end
    end

    localparam int N = perf_cnt_pkg::NUM_CNT;
    localparam bit EXT_SUP = (FAMILY == perf_cnt_pkg::EXT_FAMILY)
        && (MODEL >= perf_cnt_pkg::EXT_MIN_MODEL);

    ////////////////////////////////////////////////////////////////////////////////////
    // Counter state and per-counter wiring.

    perf_cnt_pkg::cfg_t cfg_r [N];
    perf_cnt_pkg::cfg_t cfg_nxt [N];
    logic [N-1:0] cascOrd_r;
    logic [N-1:0] cascOrd_nxt;
    logic [N-1:0] cascExt_r;
    logic [N-1:0] cascExt_nxt;
    logic [N-1:0] run;
    logic [N-1:0] loadLo;
    logic [N-1:0] loadHi;
    logic [N-1:0] clearOvf;
    logic [N-1:0] ovfFlag;
    logic [N-1:0] ovfPulse;
    logic [CNT_W-1:0] count [N];
    logic [3:0] incVal [N];

    // Event lines come from logic on the same clock, so they are used unsynchronised.
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : gCnt
            if (g < perf_cnt_pkg::SEL_CNT) begin : gSel
                assign incVal[g] = eventGroups[cfg_r[g].evSel*perf_cnt_pkg::EV_LANES +: 4];
            end else begin : gDed
                assign incVal[g] = dedicatedEvents[(g - perf_cnt_pkg::SEL_CNT)*4 +: 4];
            end
            assign run[g] = cfg_r[g].enable | cascOrd_r[g] | cascExt_r[g];
            perf_counter_unit #(
                .CNT_W(CNT_W)
            ) uCnt (
                .clock(clock),
                .rstn(rstn),
                .run(run[g]),
                .incVal(incVal[g]),
                .forceOvf(cfg_r[g].forceOvf),
                .loadLo(loadLo[g]),
                .loadHi(loadHi[g]),
                .wrData(pwdata),
                .clearOvf(clearOvf[g]),
                .count(count[g]),
                .ovfFlag(ovfFlag[g]),
                .ovfPulse(ovfPulse[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////
    // Cascade start and stop.

    always_comb begin
        int os;
        int es;
        os = 0;
        es = 0;
        for (int i = 0; i < N; i++) begin
            os = perf_cnt_pkg::ord_src(i);
            es = perf_cnt_pkg::ext_src(i);
            // Started by the source's overflow, kept while the source flag stays set.
            cascOrd_nxt[i] = cfg_r[i].cascade
                & (ovfPulse[os] | (cascOrd_r[i] & ovfFlag[os]));
            cascExt_nxt[i] = EXT_SUP && perf_cnt_pkg::ext_ok(i) && cfg_r[i].extCasc
                && (ovfPulse[es] || (cascExt_r[i] && ovfFlag[es]));
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cascOrd_r <= '0;
            cascExt_r <= '0;
        end else begin
            cascOrd_r <= cascOrd_nxt;
            cascExt_r <= cascExt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // APB slave: one setup, one access cycle with pready registered high.

    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic irq_r;
    logic irq_nxt;
    logic setupPhase;
    logic apbWrite;
    logic hit;
    logic [4:0] idx;
    logic [3:0] region;

    function automatic logic [31:0] cfg_word(input perf_cnt_pkg::cfg_t c, input logic ovf);
        logic [31:0] w;
        w = 32'h0;
        w[perf_cnt_pkg::CFG_OVF_BIT] = ovf;
        w[perf_cnt_pkg::CFG_CASC_BIT] = c.cascade;
        w[perf_cnt_pkg::CFG_IRQ_BIT] = c.irqEn;
        w[perf_cnt_pkg::CFG_FORCE_BIT] = c.forceOvf;
        w[perf_cnt_pkg::CFG_SEL_LSB +: perf_cnt_pkg::CFG_SEL_W] = c.evSel;
        w[perf_cnt_pkg::CFG_EN_BIT] = c.enable;
        w[perf_cnt_pkg::CFG_EXT_BIT] = c.extCasc;
        return w;
    endfunction

    assign setupPhase = psel & ~penable;
    assign apbWrite = psel & penable & pready_r & pwrite;
    assign idx = paddr[6:2];
    assign region = paddr[11:8];
    assign hit = (paddr[1:0] == 2'h0) && (paddr[7] == 1'b0) && (idx < 5'(N))
        && ((region == perf_cnt_pkg::REGION_CFG) || (region == perf_cnt_pkg::REGION_CNT_LO)
        || (region == perf_cnt_pkg::REGION_CNT_HI));

    always_comb begin
        logic [63:0] wide;
        prdata_nxt = prdata_r;
        pready_nxt = setupPhase;
        pslverr_nxt = setupPhase & ~hit;
        wide = 64'h0;
        if (setupPhase && hit && !pwrite) begin
            wide = 64'(count[idx]);
            unique case (region)
                perf_cnt_pkg::REGION_CFG: begin
                    prdata_nxt = cfg_word(cfg_r[idx], ovfFlag[idx]);
                end
                perf_cnt_pkg::REGION_CNT_LO: begin
                    prdata_nxt = wide[31:0];
                end
                default: begin
                    prdata_nxt = wide[63:32];
                end
            endcase
        end else if (setupPhase) begin
            prdata_nxt = 32'h0;
        end
        for (int i = 0; i < N; i++) begin
            cfg_nxt[i] = cfg_r[i];
            loadLo[i] = 1'b0;
            loadHi[i] = 1'b0;
            clearOvf[i] = 1'b0;
        end
        if (apbWrite && hit) begin
            unique case (region)
                perf_cnt_pkg::REGION_CFG: begin
                    cfg_nxt[idx].cascade = pwdata[perf_cnt_pkg::CFG_CASC_BIT];
                    cfg_nxt[idx].irqEn = pwdata[perf_cnt_pkg::CFG_IRQ_BIT];
                    cfg_nxt[idx].forceOvf = pwdata[perf_cnt_pkg::CFG_FORCE_BIT];
                    cfg_nxt[idx].evSel = pwdata[perf_cnt_pkg::CFG_SEL_LSB +: perf_cnt_pkg::CFG_SEL_W];
                    cfg_nxt[idx].enable = pwdata[perf_cnt_pkg::CFG_EN_BIT];
                    // Bit stays reserved, reading zero, outside the four permitted registers.
                    cfg_nxt[idx].extCasc = EXT_SUP && perf_cnt_pkg::ext_ok(int'(idx))
                        && pwdata[perf_cnt_pkg::CFG_EXT_BIT];
                    clearOvf[idx] = ~pwdata[perf_cnt_pkg::CFG_OVF_BIT];
                end
                perf_cnt_pkg::REGION_CNT_LO: begin
                    loadLo[idx] = 1'b1;
                end
                default: begin
                    loadHi[idx] = 1'b1;
                end
            endcase
        end
        irq_nxt = 1'b0;
        for (int i = 0; i < N; i++) begin
            irq_nxt = irq_nxt | (ovfFlag[i] & cfg_r[i].irqEn);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
            for (int i = 0; i < N; i++) begin
                cfg_r[i] <= perf_cnt_pkg::CFG_RESET;
            end
        end else begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
            for (int i = 0; i < N; i++) begin
                cfg_r[i] <= cfg_nxt[i];
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign perfmonInterrupt = irq_r;

    ////////////////////////////////////////////////////////////////////////////////////
    // Checks on counter 0 and its cascade partner 2, counter 14's source, the extended path and APB ready timing.

    default clocking cbDef @(posedge clock);
    endclocking
    default disable iff (!rstn);

    logic [CNT_W-1:0] expect0;
    assign expect0 = count[0] + CNT_W'(incVal[0]);

    chk_count_adds: assert property (
        run[0] && !loadLo[0] && !loadHi[0] |=> count[0] == $past(expect0))
        else $error("counter 0 did not add its event value");

    chk_halt_holds: assert property (
        !run[0] && !loadLo[0] && !loadHi[0] |=> $stable(count[0]))
        else $error("stopped counter 0 changed");

    chk_wrap_flag: assert property (
        run[0] && (count[0] == '1) && (incVal[0] == 4'h1) && !loadLo[0] && !loadHi[0]
        |=> ovfPulse[0] && ovfFlag[0] && (count[0] == '0))
        else $error("wrap did not set overflow flag");

    chk_flag_sticky: assert property (
        ovfFlag[0] && !clearOvf[0] |=> ovfFlag[0])
        else $error("overflow flag dropped without clear");

    chk_force_overflow_flag: assert property (
        run[0] && cfg_r[0].forceOvf && (incVal[0] != 4'h0) && !loadLo[0] && !loadHi[0]
        |=> ovfPulse[0])
        else $error("forced overflow missing");

    chk_casc_start: assert property (
        cfg_r[2].cascade && !cfg_r[2].enable && !cascOrd_r[2] && ovfPulse[0] && !apbWrite
        |-> !run[2] ##1 run[2])
        else $error("cascade start not one cycle after overflow");

    chk_casc_stop: assert property (
        cascOrd_r[2] && !ovfFlag[0] && !ovfPulse[0] |=> !cascOrd_r[2])
        else $error("cascade run kept after source flag cleared");

    chk_no_src_16: assert property (
        $rose(cascOrd_r[14]) |-> $past(ovfPulse[12]))
        else $error("counter 14 cascade-started by a wrong source");

    chk_ext_start: assert property (
        EXT_SUP && cfg_r[16].extCasc && ovfPulse[17] && !apbWrite |=> cascExt_r[16])
        else $error("extended cascade from 17 to 16 failed");

    chk_irq_raise: assert property (
        ovfFlag[0] && cfg_r[0].irqEn |=> perfmonInterrupt)
        else $error("interrupt not raised on overflow");

    chk_apb_ready: assert property (
        setupPhase |=> pready ##1 !pready)
        else $error("access phase not one cycle");

    cov_wrap: cover property (ovfPulse[0] ##1 ovfFlag[0]);
    cov_casc: cover property (ovfPulse[0] ##1 cascOrd_r[2]);
    cov_ext: cover property (ovfPulse[16] ##1 cascExt_r[17]);
    cov_read: cover property (setupPhase && !pwrite && hit ##1 pready);

endmodule

// ---- testbench/event_source.sv ----
// Event line source standing in for the processor's event logic.
`timescale 1ns/100ps
module event_source (
    input wire logic clock,
    input wire logic rstn,
    input wire logic start,
    input wire logic slow,
    input wire logic [7:0] len,
    input wire logic [31:0] grpPat,
    input wire logic [7:0] dedPat,
    output logic [31:0] eventGroups,
    output logic [7:0] dedicatedEvents,
    output logic busy
);
    logic [7:0] left_r;
    logic gap_r;
    logic drive;
    assign drive = (left_r != 8'h0) && !gap_r;
    // Slow mode idles a cycle after each event, so totals stay exact either way.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            left_r <= 8'h0;
            gap_r <= 1'b0;
        end else if (start) begin
            left_r <= len;
            gap_r <= 1'b0;
        end else if (drive) begin
            left_r <= left_r - 8'h1;
            gap_r <= slow;
        end else begin
            gap_r <= 1'b0;
        end
    end
    assign eventGroups = drive ? grpPat : 32'h0;
    assign dedicatedEvents = drive ? dedPat : 8'h0;
    assign busy = left_r != 8'h0;
endmodule

// ---- testbench/perf_counter_bank_bench.sv ----
// Self-checking bench for the event counter bank.
`timescale 1ns/100ps
module perf_counter_bank_bench;
    // A narrow counter keeps every wrap within a few events.
    localparam int CW = 8;
    localparam logic [31:0] EN = 32'h1 << perf_cnt_pkg::CFG_EN_BIT;
    localparam logic [31:0] CAS = 32'h1 << perf_cnt_pkg::CFG_CASC_BIT;
    localparam logic [31:0] EXT = 32'h1 << perf_cnt_pkg::CFG_EXT_BIT;
    localparam logic [31:0] OVF = 32'h1 << perf_cnt_pkg::CFG_OVF_BIT;
    localparam logic [31:0] IRQ = 32'h1 << perf_cnt_pkg::CFG_IRQ_BIT;
    localparam logic [31:0] FRC = 32'h1 << perf_cnt_pkg::CFG_FORCE_BIT;
    localparam logic [32:0] ERR = 33'h100000000;
    logic clock, rstn, psel, penable, pwrite, pready, pslverr, perfmonInterrupt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, grpPat, eventGroups;
    logic [7:0] len, dedPat, dedicatedEvents;
    logic start, slow, busy;
    logic [32:0] expQ[$];
    int num_errors = 0;
    int cmp_count = 0;
    int cs[10] = '{0, 3, 14, 15, 16, 17, 17, 16, 16, 12};
    int cd[10] = '{2, 1, 16, 17, 12, 15, 16, 17, 14, 16};
    bit ce[10] = '{0, 0, 0, 0, 1, 1, 1, 1, 0, 0};
    bit cg[10] = '{1, 1, 1, 1, 1, 1, 1, 1, 0, 0};

    perf_counter_bank #(.CNT_W(CW)) perf_counter_bank_inst (.clock(clock), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .eventGroups(eventGroups),
        .dedicatedEvents(dedicatedEvents), .perfmonInterrupt(perfmonInterrupt));
    event_source event_source_inst (.clock(clock), .rstn(rstn), .start(start), .slow(slow),
        .len(len), .grpPat(grpPat), .dedPat(dedPat), .eventGroups(eventGroups),
        .dedicatedEvents(dedicatedEvents), .busy(busy));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic end_sim();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (n >= 20) begin
            num_errors++;
            end_sim();
        end
    endtask

    task automatic wr(input int a, input logic [31:0] d);
        apb(1'b1, 12'(a), d);
    endtask

    task automatic rd(input int a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, 12'(a), 32'h0);
    endtask

    task automatic burst(input logic [7:0] n, input logic s);
        int k;
        k = 0;
        start <= 1'b1;
        len <= n;
        slow <= s;
        @(posedge clock);
        start <= 1'b0;
        do begin
            @(posedge clock);
            k++;
        end while (busy !== 1'b0 && k < 40);
        if (k >= 40) begin
            num_errors++;
            end_sim();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata}, expQ.size() ? expQ.pop_front() : 33'bx);
        end
    end

    initial begin
        repeat (60000) @(posedge clock);
        num_errors++;
        end_sim();
    end

    initial begin
        logic [31:0] seed, c;
        logic [2:0] sel;
        int v, s, d;
        rstn = 1'b0;
        {psel, penable, pwrite, start, slow} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        len = 8'h0;
        grpPat = 32'h0;
        dedPat = 8'h0;
        seed = 32'h5267469e;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 18; i++) begin
            rd(4 * i, 33'h0);
            rd(256 + 4 * i, 33'h0);
            rd(512 + 4 * i, 33'h0);
        end
        rd(12'h048, ERR);
        rd(12'h102, ERR);
        for (int i = 0; i < 18; i++) begin
            seed = lfsr(seed);
            grpPat <= seed;
            dedPat <= seed[23:16];
            sel = (i < 16) ? seed[26:24] : 3'h0;
            v = (i < 16) ? seed[sel * 4 +: 4] : ((i == 16) ? seed[19:16] : seed[23:20]);
            c = EN | (32'(sel) << perf_cnt_pkg::CFG_SEL_LSB);
            wr(4 * i, c);
            wr(256 + 4 * i, 32'h0);
            burst(8'h5, i[0]);
            rd(256 + 4 * i, 33'(5 * v));
            rd(512 + 4 * i, 33'h0);
            rd(4 * i, 33'(c));
            wr(4 * i, 32'h0);
            burst(8'h5, 1'b0);
            rd(256 + 4 * i, 33'(5 * v));
        end
        grpPat <= 32'h11111111;
        dedPat <= 8'h11;
        wr(4, EN | IRQ);
        wr(260, 32'hfd);
        burst(8'h2, 1'b1);
        rd(4, 33'(EN | IRQ));
        check({32'h0, perfmonInterrupt}, 33'h0);
        burst(8'h1, 1'b0);
        rd(260, 33'h0);
        rd(4, 33'(OVF | IRQ | EN));
        check({32'h0, perfmonInterrupt}, 33'h1);
        burst(8'h2, 1'b1);
        rd(260, 33'h2);
        rd(4, 33'(OVF | IRQ | EN));
        wr(4, EN | IRQ);
        rd(4, 33'(EN | IRQ));
        check({32'h0, perfmonInterrupt}, 33'h0);
        wr(4, 32'h0);
        wr(12, EN | FRC);
        wr(268, 32'h0);
        burst(8'h1, 1'b0);
        rd(268, 33'h1);
        rd(12, 33'(OVF | FRC | EN));
        wr(12, 32'h0);
        wr(48, EXT);
        rd(48, 33'(EXT));
        wr(48, 32'h0);
        wr(52, EXT);
        rd(52, 33'h0);
        wr(56, EXT);
        rd(56, 33'h0);
        for (int k = 0; k < 10; k++) begin
            s = cs[k];
            d = cd[k];
            wr(4 * d, ce[k] ? EXT : CAS);
            wr(256 + 4 * d, 32'h0);
            wr(256 + 4 * s, 32'hff);
            wr(4 * s, EN);
            burst(8'h6, 1'b0);
            rd(256 + 4 * s, 33'h5);
            rd(256 + 4 * d, cg[k] ? 33'h4 : 33'h0);
            if (cg[k]) begin
                if (k % 2) begin
                    wr(4 * d, 32'h0);
                end else begin
                    wr(4 * s, EN);
                end
                burst(8'h3, 1'b0);
                rd(256 + 4 * d, 33'h4);
                rd(256 + 4 * s, 33'h8);
            end
            wr(4 * s, 32'h0);
            wr(4 * d, 32'h0);
        end
        end_sim();
    end
endmodule
